//--- rtl/trim_setup_port.sv
// Transceiver setup port: serial register latches, I/Q trim outputs and AXI4-Lite view.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "trim_consts.svh"

module trim_setup_port #(
	parameter int NUM_REGS = `NUM_DEST_REGS,
	parameter int ADDR_W   = 8
) (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                shiftClk,
	input  wire logic                chipEnable,
	input  wire logic                serialDataIn,
	input  wire logic                serialLatchStrobe,
	output logic [3:0]               iqPhaseTrim,
	output logic                     phaseTrimOnQ,
	output logic [4:0]               iqGainTrim,
	output logic                     gainTrimOnQ,
	output logic                     trimDirectionSelect,
	input  wire logic [ADDR_W-1:0]   awaddr,
	input  wire logic                awvalid,
	output logic                     awready,
	input  wire logic [31:0]         wdata,
	input  wire logic [3:0]          wstrb,
	input  wire logic                wvalid,
	output logic                     wready,
	output trim_pkg::resp_e          bresp,
	output logic                     bvalid,
	input  wire logic                bready,
	input  wire logic [ADDR_W-1:0]   araddr,
	input  wire logic                arvalid,
	output logic                     arready,
	output logic [31:0]              rdata,
	output trim_pkg::resp_e          rresp,
	output logic                     rvalid,
	input  wire logic                rready
);
	import trim_pkg::*;

	localparam logic [3:0] LAST_IDX = 4'(NUM_REGS - 1);

	// True for a word-aligned address inside the latch window.
	function automatic logic isCfgAddr(input logic [ADDR_W-1:0] a);
		isCfgAddr = (a[1:0] == 2'h0) && (a <= ADDR_W'(`CFG_LAST_OFS));
	endfunction

	logic [`WORD_BITS-1:0] linkWord;
	logic                  sleMeta;
	logic                  sleSync;
	logic                  slePrev;
	logic                  ceMeta;
	logic                  ceSync;
	logic                  enableQ;
	logic [`WORD_BITS-1:0] regFileQ [NUM_REGS];
	logic [3:0]            lastDestQ;
	logic [15:0]           latchCountQ;

	serial_shift_port shifter (
		.shiftClk     (shiftClk),
		.rstn         (rstn),
		.chipEnable   (chipEnable),
		.serialDataIn (serialDataIn),
		.shiftWord    (linkWord)
	);

	// Strobe and chip enable are pins; two flops each, then an edge flop on the strobe.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleMeta <= 1'b0;
			sleSync <= 1'b0;
			slePrev <= 1'b0;
			ceMeta  <= 1'b0;
			ceSync  <= 1'b0;
		end else begin
			sleMeta <= serialLatchStrobe;
			sleSync <= sleMeta;
			slePrev <= sleSync;
			ceMeta  <= chipEnable;
			ceSync  <= ceMeta;
		end
	end

	// The shift word is steady while the strobe is high, so it is copied on the strobe edge.
	wire       sleRise   = sleSync && !slePrev;
	wire [3:0] destIdx   = linkWord[`DEST_MSB:`DEST_LSB];
	wire       destValid = destIdx <= LAST_IDX;
	wire       latchFire = sleRise && ceSync && enableQ && destValid;
	wire       trimFire  = latchFire && (destIdx == `TRIM_REG_IDX);

	// Latch bank: the low four bits of the word pick the destination.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regFileQ[i] <= '0;
			end
			lastDestQ   <= 4'h0;
			latchCountQ <= 16'h0000;
		end else if (latchFire) begin
			regFileQ[destIdx] <= linkWord;
			lastDestQ         <= destIdx;
			latchCountQ       <= latchCountQ + 16'h0001;
		end
	end

	// Trim fields leave the block straight from their own flops.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			iqPhaseTrim         <= 4'h0;
			phaseTrimOnQ        <= 1'b0;
			iqGainTrim          <= 5'h00;
			gainTrimOnQ         <= 1'b0;
			trimDirectionSelect <= 1'b0;
		end else if (trimFire) begin
			iqPhaseTrim         <= linkWord[`PHASE_MSB:`PHASE_LSB];
			phaseTrimOnQ        <= linkWord[`PHASE_SEL_BIT];
			iqGainTrim          <= linkWord[`GAIN_MSB:`GAIN_LSB];
			gainTrimOnQ         <= linkWord[`GAIN_SEL_BIT];
			trimDirectionSelect <= linkWord[`DIR_SEL_BIT];
		end
	end

	// Write channel: address and data are collected in any order, then answered.
	wr_state_e         wrStateQ;
	wr_state_e         wrStateD;
	logic              awHeldQ;
	logic              wHeldQ;
	logic [ADDR_W-1:0] awAddrQ;
	logic [31:0]       wDataQ;
	logic [3:0]        wStrbQ;

	wire awFire   = awvalid && awready;
	wire wFire    = wvalid && wready;
	wire bFire    = bvalid && bready;
	wire awHeldD  = (awHeldQ || awFire) && !bFire;
	wire wHeldD   = (wHeldQ || wFire) && !bFire;
	wire bothHeld = awHeldD && wHeldD && (wrStateQ == WR_COLLECT);
	wire ctrlHit  = awAddrQ == ADDR_W'(`CTRL_OFS);
	wire doWrite  = (wrStateQ == WR_ANSWER) && !bvalid;
	wire [ADDR_W-1:0] wrAddrNow = awFire ? awaddr : awAddrQ;

	assign wrStateD = bothHeld ? WR_ANSWER : (bFire ? WR_COLLECT : wrStateQ);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrStateQ <= WR_COLLECT;
			awHeldQ  <= 1'b0;
			wHeldQ   <= 1'b0;
			awready  <= 1'b0;
			wready   <= 1'b0;
			awAddrQ  <= '0;
			wDataQ   <= 32'h0000_0000;
			wStrbQ   <= 4'h0;
		end else begin
			wrStateQ <= wrStateD;
			awHeldQ  <= awHeldD;
			wHeldQ   <= wHeldD;
			awready  <= (wrStateD == WR_COLLECT) && !awHeldD;
			wready   <= (wrStateD == WR_COLLECT) && !wHeldD;
			awAddrQ  <= wrAddrNow;
			if (wFire) begin
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
		end
	end

	// Response and the control write; only the control word is writable.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			enableQ <= `CTRL_RESET;
		end else begin
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp  <= ctrlHit ? RESP_OKAY : RESP_SLVERR;
				if (ctrlHit && wStrbQ[0]) begin
					enableQ <= wDataQ[0];
				end
			end else if (bFire) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read decode: latches, status, control, error elsewhere.
	rd_state_e rdStateQ;
	wire       arFire     = arvalid && arready;
	wire       rFire      = rvalid && rready;
	wire       rdCfgHit   = isCfgAddr(araddr);
	wire       rdStatHit  = araddr == ADDR_W'(`STATUS_OFS);
	wire       rdCtrlHit  = araddr == ADDR_W'(`CTRL_OFS);
	wire [31:0] statusWord = {latchCountQ, 11'h000, ceSync, lastDestQ};
	wire [31:0] ctrlWord   = {31'h0000_0000, enableQ};
	wire [31:0] rdWord     = rdCfgHit  ? regFileQ[araddr[5:2]] :
	                         rdStatHit ? statusWord :
	                         rdCtrlHit ? ctrlWord : 32'h0000_0000;
	wire        rdOk       = rdCfgHit || rdStatHit || rdCtrlHit;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdStateQ <= RD_IDLE;
			arready  <= 1'b0;
			rvalid   <= 1'b0;
			rdata    <= 32'h0000_0000;
			rresp    <= RESP_OKAY;
		end else begin
			case (rdStateQ)
				RD_IDLE: begin
					arready <= !arFire;
					if (arFire) begin
						rdStateQ <= RD_DATA;
						rvalid   <= 1'b1;
						rdata    <= rdWord;
						rresp    <= rdOk ? RESP_OKAY : RESP_SLVERR;
					end
				end
				RD_DATA: begin
					if (rFire) begin
						rdStateQ <= RD_IDLE;
						rvalid   <= 1'b0;
						arready  <= 1'b1;
					end
				end
				default: begin
					rdStateQ <= RD_IDLE;
				end
			endcase
		end
	end

	// Checks on the latch path and on the bus.
	a_phase_magnitude: assert property (@(posedge clk) disable iff (!rstn)
		trimFire |=> iqPhaseTrim == $past(linkWord[`PHASE_MSB:`PHASE_LSB]))
		else $error("Phase trim magnitude not taken from register 10.");

	a_phase_channel: assert property (@(posedge clk) disable iff (!rstn)
		trimFire |=> phaseTrimOnQ == $past(linkWord[`PHASE_SEL_BIT]))
		else $error("Phase trim channel select not taken from register 10.");

	a_gain_magnitude: assert property (@(posedge clk) disable iff (!rstn)
		trimFire |=> iqGainTrim == $past(linkWord[`GAIN_MSB:`GAIN_LSB]))
		else $error("Gain trim magnitude not taken from register 10.");

	a_gain_channel: assert property (@(posedge clk) disable iff (!rstn)
		trimFire |=> gainTrimOnQ == $past(linkWord[`GAIN_SEL_BIT]))
		else $error("Gain trim channel select not taken from register 10.");

	a_gain_direction: assert property (@(posedge clk) disable iff (!rstn)
		(latchFire && destIdx != `TRIM_REG_IDX) |=> $stable(trimDirectionSelect))
		else $error("Trim direction moved on a write to another register.");

	a_gain_dir_take: assert property (@(posedge clk) disable iff (!rstn)
		trimFire |=> trimDirectionSelect == $past(linkWord[`DIR_SEL_BIT]))
		else $error("Trim direction not taken from register 10.");

	a_dest_select: assert property (@(posedge clk) disable iff (!rstn)
		latchFire |=> (lastDestQ == $past(destIdx)) && (regFileQ[lastDestQ] == $past(linkWord)))
		else $error("Word did not land in the register its low bits name.");

	a_ce_gates_latch: assert property (@(posedge clk) disable iff (!rstn)
		(sleRise && !ceSync) |=> $stable(latchCountQ))
		else $error("A strobe was honoured while chip enable was low.");

	a_strobe_latches: assert property (@(posedge clk) disable iff (!rstn)
		$rose(sleSync) && ceSync && enableQ && destValid |=> latchCountQ == $past(latchCountQ) + 16'h0001)
		else $error("Rising strobe did not latch the word.");

	a_bvalid_holds: assert property (@(posedge clk) disable iff (!rstn)
		(bvalid && !bready) |=> bvalid && $stable(bresp))
		else $error("Write response dropped before it was taken.");

	a_rvalid_holds: assert property (@(posedge clk) disable iff (!rstn)
		(rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("Read data dropped before it was taken.");

	a_write_refused: assert property (@(posedge clk) disable iff (!rstn)
		(doWrite && !ctrlHit) |=> $stable(enableQ) && (bresp == RESP_SLVERR))
		else $error("A write outside the control word was not refused.");

	c_trim_write: cover property (@(posedge clk) disable iff (!rstn) trimFire);
	c_dest_refused: cover property (@(posedge clk) disable iff (!rstn)
		sleRise && ceSync && !destValid);
	c_write_refused: cover property (@(posedge clk) disable iff (!rstn)
		bFire && bresp == RESP_SLVERR);
	c_ce_low_strobe: cover property (@(posedge clk) disable iff (!rstn) sleRise && !ceSync);
	c_read_answer: cover property (@(posedge clk) disable iff (!rstn) rFire && rresp == RESP_OKAY);

endmodule // trim_setup_port

//--- rtl/trim_consts.svh
// Offsets, field positions and reset values of the transceiver setup port.
`ifndef TRIM_CONSTS_SVH
`define TRIM_CONSTS_SVH

`define WORD_BITS        32
`define NUM_DEST_REGS    14
`define DEST_MSB         3
`define DEST_LSB         0
`define TRIM_REG_IDX     4'hA
`define PHASE_MSB        27
`define PHASE_LSB        24
`define PHASE_SEL_BIT    28
`define GAIN_MSB         20
`define GAIN_LSB         16
`define GAIN_SEL_BIT     22
`define DIR_SEL_BIT      21
`define CFG_LAST_OFS     8'h34
`define STATUS_OFS       8'h38
`define CTRL_OFS         8'h3C
`define CTRL_RESET       1'b1
`define STAT_CE_BIT      4
`define STAT_COUNT_LSB   16

`endif

//--- rtl/trim_pkg.sv
// Types shared by the setup port and its register bus slave.
package trim_pkg;
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} resp_e;

	typedef enum logic [0:0] {
		WR_COLLECT = 1'b0,
		WR_ANSWER  = 1'b1
	} wr_state_e;

	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_e;
endpackage

//--- rtl/serial_shift_port.sv
// Shift register of the three-wire setup port, running on the shift clock.
`timescale 1ns/1ps
`include "trim_consts.svh"

module serial_shift_port (
	input  wire logic                  shiftClk,
	input  wire logic                  rstn,
	input  wire logic                  chipEnable,
	input  wire logic                  serialDataIn,
	output logic [`WORD_BITS-1:0]      shiftWord
);
	logic ceMeta;
	logic ceLink;

	// Chip enable comes from a pin, so it is synchronised before use.
	always_ff @(posedge shiftClk or negedge rstn) begin
		if (!rstn) begin
			ceMeta <= 1'b0;
			ceLink <= 1'b0;
		end else begin
			ceMeta <= chipEnable;
			ceLink <= ceMeta;
		end
	end

	// Data enters at bit 0 on each rising edge while the synchronised chip enable is high, so the first bit ends up on top.
	always_ff @(posedge shiftClk or negedge rstn) begin
		if (!rstn) begin
			shiftWord <= '0;
		end else if (ceLink) begin
			shiftWord <= {shiftWord[`WORD_BITS-2:0], serialDataIn};
		end
	end

	a_shift_msb_first: assert property (@(posedge shiftClk) disable iff (!rstn)
		ceLink |=> shiftWord == {$past(shiftWord[`WORD_BITS-2:0]), $past(serialDataIn)})
		else $error("Shift word did not take the serial bit at the bottom.");

	a_shift_idle_no_ce: assert property (@(posedge shiftClk) disable iff (!rstn)
		!ceLink |=> $stable(shiftWord))
		else $error("Shift word moved while chip enable was low.");

endmodule // serial_shift_port

//--- bench/host_serial_model.sv
// Behavioural host that shifts words into the three-wire setup port.
`timescale 1ns/1ps

module host_serial_model (
	output logic shiftClk,
	output logic serialDataIn,
	output logic serialLatchStrobe
);
	// The link idles with its clock still and the strobe low.
	initial begin
		shiftClk = 1'b0;
		serialDataIn = 1'b0;
		serialLatchStrobe = 1'b0;
	end

	// Two lead-in pulses let the port's chip enable synchroniser settle before a word.
	task automatic wake();
		for (int i = 0; i < 2; i++) begin
			serialDataIn = i[0];
			#16 shiftClk = 1'b1;
			#16 shiftClk = 1'b0;
		end
		#16;
	endtask

	// Shifts a whole word MSB first, then strobes it; released data is inverted.
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			serialDataIn = w[i];
			#16 shiftClk = 1'b1;
			#16 shiftClk = 1'b0;
		end
		#16 serialLatchStrobe = 1'b1;
		#320 serialLatchStrobe = 1'b0;
		serialDataIn = ~w[0];
		#320;
	endtask
endmodule // host_serial_model

//--- bench/tb.sv
// Self-checking bench of the setup port: serial words in, AXI4-Lite reads back.
`timescale 1ns/1ps
`include "trim_consts.svh"

module tb;
	import trim_pkg::*;
	logic        clk = 0, rstn = 0, chipEnable = 0;
	logic        shiftClk, serialDataIn, serialLatchStrobe;
	logic [3:0]  iqPhaseTrim;
	logic [4:0]  iqGainTrim;
	logic        phaseTrimOnQ, gainTrimOnQ, trimDirectionSelect;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	resp_e       bresp, rresp, rs;
	int          fails = 0, totalChecks = 0, cnt = 0;
	logic [3:0]  wstrb = 4'hF, lastDst = 4'h0;
	// Payload rate code of the receive clock word; an arbitrary bench value.
	localparam logic [11:0] BIT_RATE = 12'h060;
	logic [31:0] regs [16];

	// System clock of 40 ns.
	always #20 clk = ~clk;

	trim_setup_port uut (.clk(clk), .rstn(rstn), .shiftClk(shiftClk), .chipEnable(chipEnable),
		.serialDataIn(serialDataIn), .serialLatchStrobe(serialLatchStrobe),
		.iqPhaseTrim(iqPhaseTrim), .phaseTrimOnQ(phaseTrimOnQ), .iqGainTrim(iqGainTrim),
		.gainTrimOnQ(gainTrimOnQ), .trimDirectionSelect(trimDirectionSelect),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	host_serial_model host (.shiftClk(shiftClk), .serialDataIn(serialDataIn),
		.serialLatchStrobe(serialLatchStrobe));

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_resp(input resp_e got, input resp_e exp);
		totalChecks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t response %b expected %b", $time, got, exp);
		end
	endtask

	// Write with address and data offered together; each is released when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output resp_e r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output resp_e r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	// Sends a word and keeps the model of what the latches should hold.
	task automatic put(input logic [31:0] w, input logic counts);
		host.send(w);
		@(posedge clk);
		if (counts) begin
			regs[w[3:0]] = w;
			lastDst = w[3:0];
			cnt++;
		end
	endtask

	task automatic check_trim(input logic [31:0] w);
		check_val({20'h0, iqPhaseTrim, phaseTrimOnQ, iqGainTrim, gainTrimOnQ,
			trimDirectionSelect}, {20'h0, w[`PHASE_MSB:`PHASE_LSB], w[`PHASE_SEL_BIT],
			w[`GAIN_MSB:`GAIN_LSB], w[`GAIN_SEL_BIT], w[`DIR_SEL_BIT]});
	endtask

	task automatic check_regs();
		foreach (regs[i]) if (i < 14) begin
			axi_rd(8'(4 * i), rd, rs);
			check_resp(rs, RESP_OKAY);
			check_val(rd, regs[i]);
		end
		axi_rd(`STATUS_OFS, rd, rs);
		check_val(rd, {16'(cnt), 11'h0, 1'b1, lastDst});
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Watchdog against a hang of the bus or the link.
	initial begin
		#2000000;
		fails++;
		finish_test();
	end

	// Main sequence of tests.
	initial begin
		foreach (regs[i]) regs[i] = 32'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		chipEnable <= 1'b1;
		repeat (6) @(posedge clk);
		check_trim(32'h0);
		axi_rd(`CTRL_OFS, rd, rs);
		check_val(rd, 32'(`CTRL_RESET));
		$display("test reset done");
		host.wake();
		for (int i = 0; i < 14; i++) put({8'hC0 + 8'(i), 8'h5A, 8'h3C, 4'h9, 4'(i)}, 1'b1);
		check_regs();
		$display("test all destinations done");
		put(regs[0] ^ 32'h0020_0000, 1'b1);
		check_regs();
		$display("test divider rewrite done");
		put(32'h1A15_000A, 1'b1);
		check_trim(32'h1A15_000A);
		put(32'h0560_000A, 1'b1);
		check_trim(32'h0560_000A);
		$display("test trim fields done");
		// Receive clock word at the chip rate, twice the payload rate, divider of 32.
		put({8'h00, 12'(2 * BIT_RATE), 8'h20, 4'h3}, 1'b1);
		put(32'h1A15_000E, 1'b0);
		put(32'h1A15_000F, 1'b0);
		chipEnable <= 1'b0;
		repeat (4) @(posedge clk);
		put(32'h1A15_000A, 1'b0);
		check_trim(32'h0560_000A);
		chipEnable <= 1'b1;
		host.wake();
		repeat (4) @(posedge clk);
		axi_wr(`CTRL_OFS, 32'h0, rs);
		check_resp(rs, RESP_OKAY);
		put(32'h1A15_000A, 1'b0);
		check_trim(32'h0560_000A);
		axi_wr(`CTRL_OFS, 32'h1, rs);
		check_resp(rs, RESP_OKAY);
		wstrb <= 4'h0;
		axi_wr(`CTRL_OFS, 32'h0, rs);
		wstrb <= 4'hF;
		axi_rd(`CTRL_OFS, rd, rs);
		check_val(rd, 32'h0000_0001);
		axi_wr(8'h00, 32'hFFFF_FFFF, rs);
		check_resp(rs, RESP_SLVERR);
		axi_rd(8'h40, rd, rs);
		check_resp(rs, RESP_SLVERR);
		check_val(rd, 32'h0);
		check_regs();
		$display("test refusals done");
		finish_test();
	end
endmodule // tb
